// >>> core/line_alarm_pkg.sv
package line_alarm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] INTERRUPT_ENABLE_IDX = 8'h04;
  localparam logic [7:0] ALARM_STATUS_IDX     = 8'h05;
  localparam logic [7:0] INTERRUPT_ENABLE_ADDR = 8'h10;
  localparam logic [7:0] ALARM_STATUS_ADDR     = 8'h14;

  // Reset values
  localparam logic [7:0] INTERRUPT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] ALARM_STATUS_RESET     = 8'h00;

  // Bit positions shared by both registers, except bit 7: global enable only, reserved zero in status
  localparam int GLOBAL_IRQ_BIT   = 7;
  localparam int DRIVER_FAULT_BIT = 6;
  localparam int FIFO_LIMIT_BIT   = 5;
  localparam int CODE_VIOL_BIT    = 4;
  localparam int LOOP_CODE_BIT    = 3;
  localparam int ALL_ONES_BIT     = 2;
  localparam int SIGNAL_LOST_BIT  = 1;
  localparam int PATTERN_SYNC_BIT = 0;

  // Loop-code hold time and derived cycle count
  localparam longint CLK_HZ          = 100000000;
  localparam longint LOOP_HOLD_S     = 5;
  localparam logic [31:0] LOOP_HOLD_CYCLES = 32'(LOOP_HOLD_S * CLK_HZ);
  localparam logic [31:0] LOOP_CNT_RESET   = 32'h0000_0000;

  // Loop-code detection modes
  typedef enum logic [1:0] {
    LOOP_OFF      = 2'b00,
    LOOP_MANUAL_A = 2'b01,
    LOOP_MANUAL_B = 2'b10,
    LOOP_AUTO     = 2'b11
  } loop_mode_type;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avalon_req_type;

  // Live detector levels, all on the block clock
  typedef struct packed {
    logic driver_fault;
    logic fifo_near_limit;
    logic code_violation;
    logic loop_pattern_present;
    logic auto_loop_active;
    logic all_ones_detected;
    logic rx_signal_lost;
    logic pattern_sync;
  } alarm_in_type;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]  enable;
    logic [7:0]  status;
    logic [6:0]  pending;
    logic        ack;
    logic [31:0] readdata;
    logic [31:0] loop_cnt;
  } alarm_state_type;

endpackage : line_alarm_pkg

// >>> core/line_alarm_interrupt_logic.sv
`timescale 1ns/1ps
`default_nettype none
module line_alarm_interrupt_logic
  import line_alarm_pkg::*;
#(
  parameter logic [31:0] LOOP_HOLD = LOOP_HOLD_CYCLES
) (
  input  wire logic           ref_clk,
  input  wire logic           reset,
  input  wire avalon_req_type avm,
  output logic                waitrequest,
  output logic [31:0]         readdata,
  input  wire alarm_in_type   alarm_in,
  input  wire loop_mode_type  loop_mode,
  output logic [6:0]          status_change,
  output logic                irq
);

  alarm_state_type state;
  alarm_state_type next_state;
  logic [7:0]      next_status;
  logic            request;
  logic            loop_manual;

  // Bus request and its one-cycle wait
  assign request     = avm.read | avm.write;
  assign waitrequest = request & ~state.ack;
  assign readdata    = state.readdata;
  assign loop_manual = (loop_mode == LOOP_MANUAL_A) ||
                       (loop_mode == LOOP_MANUAL_B);

  // Pin needs global enable and an enabled recorded edge
  assign irq = state.enable[GLOBAL_IRQ_BIT] & (|state.pending);
  assign status_change = state.pending;

  // Next state
  always_comb begin
    next_state  = state;
    next_status = 8'h00;
    // Live detector levels
    next_status[DRIVER_FAULT_BIT] = alarm_in.driver_fault;
    next_status[FIFO_LIMIT_BIT]   = alarm_in.fifo_near_limit;
    next_status[CODE_VIOL_BIT]    = alarm_in.code_violation;
    next_status[ALL_ONES_BIT]     = alarm_in.all_ones_detected;
    next_status[SIGNAL_LOST_BIT]  = alarm_in.rx_signal_lost;
    next_status[PATTERN_SYNC_BIT] = alarm_in.pattern_sync;
    // Loop-code bit by detection mode
    next_status[LOOP_CODE_BIT] = 1'b0;
    next_state.loop_cnt = LOOP_CNT_RESET;
    if (loop_manual) begin
      if (alarm_in.loop_pattern_present) begin
        if (state.loop_cnt >= LOOP_HOLD - 32'h0000_0001) begin
          next_state.loop_cnt = state.loop_cnt;
          next_status[LOOP_CODE_BIT] = 1'b1;
        end else begin
          next_state.loop_cnt = state.loop_cnt + 32'h0000_0001;
        end
      end
    end else if (loop_mode == LOOP_AUTO) begin
      next_status[LOOP_CODE_BIT] = alarm_in.auto_loop_active;
    end
    next_state.status = next_status;
    // Bus access: first edge loads data, second completes
    if (request && !state.ack) begin
      next_state.ack = 1'b1;
      if (avm.address == INTERRUPT_ENABLE_ADDR) begin
        next_state.readdata = {24'h000000, state.enable};
      end else if (avm.address == ALARM_STATUS_ADDR) begin
        next_state.readdata = {24'h000000, state.status};
      end else begin
        next_state.readdata = 32'h0000_0000;
      end
    end else if (request && state.ack) begin
      next_state.ack = 1'b0;
      if (avm.write && avm.byteenable[0] &&
          avm.address == INTERRUPT_ENABLE_ADDR) begin
        next_state.enable = avm.writedata[7:0];
      end
      if (avm.read && avm.address == ALARM_STATUS_ADDR) begin
        next_state.pending = 7'h00;
      end
    end else begin
      next_state.ack = 1'b0;
    end
    // Enabled edges record; set wins over read clear
    next_state.pending = next_state.pending |
      ((next_status[6:0] ^ state.status[6:0]) & state.enable[6:0]);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state.enable   <= INTERRUPT_ENABLE_RESET;
      state.status   <= ALARM_STATUS_RESET;
      state.pending  <= 7'h00;
      state.ack      <= 1'b0;
      state.readdata <= 32'h0000_0000;
      state.loop_cnt <= LOOP_CNT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Checks
  AST_GIE_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    !state.enable[GLOBAL_IRQ_BIT] |-> !irq)
    else $error("interrupt pin high with global enable clear");

  AST_IRQ_CAUSE: assert property (@(posedge ref_clk) disable iff (reset)
    (state.enable[GLOBAL_IRQ_BIT] && (|state.pending)) == irq)
    else $error("interrupt pin does not match enabled pending edges");

  AST_DRV_LIVE: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> state.status[DRIVER_FAULT_BIT] ==
                      $past(alarm_in.driver_fault))
    else $error("driver fault status not live");

  AST_DRV_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    ($changed(state.status[DRIVER_FAULT_BIT]) &&
     $past(state.enable[DRIVER_FAULT_BIT])) |-> state.pending[6])
    else $error("driver fault edge not recorded");

  AST_DRV_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (!$past(state.enable[DRIVER_FAULT_BIT]) && !$past(state.pending[6]))
    |-> !state.pending[6])
    else $error("masked driver fault edge recorded");

  AST_FIFO_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    ($changed(state.status[FIFO_LIMIT_BIT]) &&
     $past(state.enable[FIFO_LIMIT_BIT])) |-> state.pending[5])
    else $error("fifo limit edge not recorded");

  AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
    !state.status[7])
    else $error("reserved status bit set");

  AST_LOOP_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
    ($past(loop_manual) && !$past(alarm_in.loop_pattern_present))
    |-> !state.status[LOOP_CODE_BIT])
    else $error("loop code bit held after pattern stopped");

  AST_WAIT_BOUND: assert property (@(posedge ref_clk) disable iff (reset)
    (request && waitrequest) |=> !waitrequest)
    else $error("waitrequest held more than one cycle");

  AST_ENABLE_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    (avm.write && !waitrequest && avm.byteenable[0] &&
     avm.address == INTERRUPT_ENABLE_ADDR)
    |=> state.enable == $past(avm.writedata[7:0]))
    else $error("enable register write lost");

  COV_IRQ: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(irq));
  COV_STATUS_CLEAR: cover property (@(posedge ref_clk) disable iff (reset)
    avm.read && !waitrequest && avm.address == ALARM_STATUS_ADDR && irq);
  COV_LOOP_SET: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(state.status[LOOP_CODE_BIT]));

  // Loop-code bit dropping after the pattern stops
  COV_LOOP_CLEAR: cover property (@(posedge ref_clk) disable iff (reset)
    $fell(state.status[LOOP_CODE_BIT]));

  // Edge recorded while the pin is globally masked
  COV_MASKED_EDGE: cover property (@(posedge ref_clk) disable iff (reset)
    (|state.pending) && !state.enable[GLOBAL_IRQ_BIT]);

  // FIFO-limit status follows its detector
  AST_FIFO_LIVE: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> state.status[FIFO_LIMIT_BIT] ==
                      $past(alarm_in.fifo_near_limit))
    else $error("fifo limit status not live");

  // Code-violation status follows its detector
  AST_CODE_LIVE: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> state.status[CODE_VIOL_BIT] ==
                      $past(alarm_in.code_violation))
    else $error("code violation status not live");

  // All-ones status follows its detector
  AST_ONES_LIVE: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> state.status[ALL_ONES_BIT] ==
                      $past(alarm_in.all_ones_detected))
    else $error("all ones status not live");

  // Signal-lost status follows its detector
  AST_LOST_LIVE: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> state.status[SIGNAL_LOST_BIT] ==
                      $past(alarm_in.rx_signal_lost))
    else $error("signal lost status not live");

  // Pattern-sync status follows its detector
  AST_SYNC_LIVE: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> state.status[PATTERN_SYNC_BIT] ==
                      $past(alarm_in.pattern_sync))
    else $error("pattern sync status not live");

  // Enabled code-violation edge is recorded
  AST_CODE_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    ($changed(state.status[CODE_VIOL_BIT]) &&
     $past(state.enable[CODE_VIOL_BIT])) |-> state.pending[4])
    else $error("code violation edge not recorded");

  // Enabled loop-code edge is recorded
  AST_LOOP_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    ($changed(state.status[LOOP_CODE_BIT]) &&
     $past(state.enable[LOOP_CODE_BIT])) |-> state.pending[3])
    else $error("loop code edge not recorded");

  // Enabled all-ones edge is recorded
  AST_ONES_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    ($changed(state.status[ALL_ONES_BIT]) &&
     $past(state.enable[ALL_ONES_BIT])) |-> state.pending[2])
    else $error("all ones edge not recorded");

  // Enabled signal-lost edge is recorded
  AST_LOST_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    ($changed(state.status[SIGNAL_LOST_BIT]) &&
     $past(state.enable[SIGNAL_LOST_BIT])) |-> state.pending[1])
    else $error("signal lost edge not recorded");

  // Enabled pattern-sync edge is recorded
  AST_SYNC_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    ($changed(state.status[PATTERN_SYNC_BIT]) &&
     $past(state.enable[PATTERN_SYNC_BIT])) |-> state.pending[0])
    else $error("pattern sync edge not recorded");

  // Masked FIFO-limit edge stays unrecorded
  AST_FIFO_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (!$past(state.enable[FIFO_LIMIT_BIT]) && !$past(state.pending[5]))
    |-> !state.pending[5])
    else $error("masked fifo limit edge recorded");

  // Masked code-violation edge stays unrecorded
  AST_CODE_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (!$past(state.enable[CODE_VIOL_BIT]) && !$past(state.pending[4]))
    |-> !state.pending[4])
    else $error("masked code violation edge recorded");

  // Masked loop-code edge stays unrecorded
  AST_LOOP_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (!$past(state.enable[LOOP_CODE_BIT]) && !$past(state.pending[3]))
    |-> !state.pending[3])
    else $error("masked loop code edge recorded");

  // Masked all-ones edge stays unrecorded
  AST_ONES_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (!$past(state.enable[ALL_ONES_BIT]) && !$past(state.pending[2]))
    |-> !state.pending[2])
    else $error("masked all ones edge recorded");

  // Masked signal-lost edge stays unrecorded
  AST_LOST_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (!$past(state.enable[SIGNAL_LOST_BIT]) && !$past(state.pending[1]))
    |-> !state.pending[1])
    else $error("masked signal lost edge recorded");

  // Masked pattern-sync edge stays unrecorded
  AST_SYNC_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (!$past(state.enable[PATTERN_SYNC_BIT]) && !$past(state.pending[0]))
    |-> !state.pending[0])
    else $error("masked pattern sync edge recorded");

  // Upper read data lanes always zero
  AST_READ_UPPER: assert property (@(posedge ref_clk) disable iff (reset)
    readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  // Enable register changes only by a completed write to it
  AST_ENABLE_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    !(avm.write && !waitrequest && avm.byteenable[0] &&
      avm.address == INTERRUPT_ENABLE_ADDR) |=> $stable(state.enable))
    else $error("enable register changed without a write");

  // Completed status read leaves only fresh enabled edges
  AST_READ_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
    (avm.read && !waitrequest && avm.address == ALARM_STATUS_ADDR)
    |=> state.pending == ((state.status[6:0] ^ $past(state.status[6:0])) &
                          $past(state.enable[6:0])))
    else $error("status read did not clear recorded edges");

  // Recorded edges persist until a status read
  AST_PEND_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    !(avm.read && !waitrequest && avm.address == ALARM_STATUS_ADDR)
    |=> (state.pending & $past(state.pending)) == $past(state.pending))
    else $error("recorded edge lost without a read");

  // A recorded edge needs a status transition behind it
  AST_PEND_SOURCE: assert property (@(posedge ref_clk) disable iff (reset)
    (state.pending & ~$past(state.pending) &
     ~(state.status[6:0] ^ $past(state.status[6:0]))) == 7'h00)
    else $error("edge recorded without a status change");

  // First cycle of a new request always waits
  AST_WAIT_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
    (request && !$past(request)) |-> waitrequest)
    else $error("new request answered without a wait");

  // Enable read returns the register contents
  AST_READ_ENABLE: assert property (@(posedge ref_clk) disable iff (reset)
    (avm.read && !waitrequest && avm.address == INTERRUPT_ENABLE_ADDR)
    |-> readdata == {24'h000000, state.enable})
    else $error("enable read data wrong");

  // Status read returns the status sampled at request time
  AST_READ_STATUS: assert property (@(posedge ref_clk) disable iff (reset)
    (avm.read && !waitrequest && avm.address == ALARM_STATUS_ADDR)
    |-> readdata[7:0] == $past(state.status))
    else $error("status read data wrong");

  // Unmapped reads return zero
  AST_READ_UNMAPPED: assert property (@(posedge ref_clk) disable iff (reset)
    (avm.read && !waitrequest && avm.address != ALARM_STATUS_ADDR &&
     avm.address != INTERRUPT_ENABLE_ADDR) |-> readdata == 32'h0000_0000)
    else $error("unmapped read data not zero");

  // Loop-code bit stays low with detection off
  AST_LOOP_OFF: assert property (@(posedge ref_clk) disable iff (reset)
    ($past(loop_mode) == LOOP_OFF) |-> !state.status[LOOP_CODE_BIT])
    else $error("loop code bit set with detection off");

  // Automatic mode mirrors the remote loopback state
  AST_LOOP_AUTO: assert property (@(posedge ref_clk) disable iff (reset)
    (!$past(reset) && $past(loop_mode) == LOOP_AUTO)
    |-> state.status[LOOP_CODE_BIT] == $past(alarm_in.auto_loop_active))
    else $error("loop code bit does not follow automatic loopback");

  // Hold counter idles outside manual mode
  AST_LOOP_CNT_IDLE: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(loop_manual) |-> state.loop_cnt == LOOP_CNT_RESET)
    else $error("loop hold counter running outside manual mode");

  // Pin stays low with nothing recorded
  AST_IRQ_IDLE: assert property (@(posedge ref_clk) disable iff (reset)
    !(|state.pending) |-> !irq)
    else $error("interrupt pin high with nothing recorded");

endmodule : line_alarm_interrupt_logic
`default_nettype wire

// >>> test/host_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_master_model
  import line_alarm_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         waitrequest,
  input  wire logic [31:0]  readdata,
  output var avalon_req_type avm
);
  initial avm = '0;
  // One Avalon access, held until waitrequest is seen low or 20 cycles pass
  task automatic access(input logic wr, input logic [7:0] a,
    input logic [7:0] d, input logic [3:0] be,
    output logic [7:0] q, output logic ok);
    int n;
    q  = 8'h00;
    ok = 1'b0;
    @(posedge ref_clk);
    avm <= '{a, ~wr, wr, {24'h000000, d}, be};
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) begin
        ok = 1'b1;
        q  = readdata[7:0];
      end
    end
    avm.read  <= 1'b0;
    avm.write <= 1'b0;
  endtask : access
endmodule : host_master_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import line_alarm_pkg::*;
;
  logic           ref_clk, reset, waitrequest, irq;
  logic [31:0]    readdata;
  logic [6:0]     status_change;
  avalon_req_type avm;
  alarm_in_type   alarm_in;
  loop_mode_type  loop_mode;
  logic [7:0]     d, m, o;
  int             fails, samples_checked;

  line_alarm_interrupt_logic #(.LOOP_HOLD(32'h00000008))
    line_alarm_interrupt_logic_inst (.ref_clk(ref_clk), .reset(reset),
    .avm(avm), .waitrequest(waitrequest), .readdata(readdata),
    .alarm_in(alarm_in), .loop_mode(loop_mode),
    .status_change(status_change), .irq(irq));
  host_master_model host_master_model_inst (.ref_clk(ref_clk),
    .waitrequest(waitrequest), .readdata(readdata), .avm(avm));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task print_verdict;
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Register access; a lost answer ends the run
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] v,
    input logic [3:0] be);
    logic ok;
    host_master_model_inst.access(wr, a, v, be, d, ok);
    // Let the completion edge settle before outputs are compared
    @(posedge ref_clk);
    if (!ok) begin
      fails++;
      print_verdict;
    end
  endtask : bus

  // Detector levels in status bit order, bit 3 via auto loop input
  task det(input logic [7:0] v);
    @(posedge ref_clk);
    alarm_in <= '{v[6], v[5], v[4], 1'b0, v[3], v[2], v[1], v[0]};
    repeat (2) @(posedge ref_clk);
  endtask : det

  task t_regs;
    bus(1'b0, INTERRUPT_ENABLE_ADDR, 8'h00, 4'hF);
    chk(d, INTERRUPT_ENABLE_RESET);
    bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
    chk(d, ALARM_STATUS_RESET);
    bus(1'b1, INTERRUPT_ENABLE_ADDR, 8'h5A, 4'h1);
    bus(1'b1, INTERRUPT_ENABLE_ADDR, 8'hFF, 4'hE);
    bus(1'b1, 8'h18, 8'hFF, 4'hF);
    bus(1'b1, ALARM_STATUS_ADDR, 8'hFF, 4'hF);
    bus(1'b0, INTERRUPT_ENABLE_ADDR, 8'h00, 4'hF);
    chk(d, 8'h5A);
    bus(1'b0, 8'h18, 8'h00, 4'hF);
    chk(d, 8'h00);
    bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
    chk(d, 8'h00);
  endtask : t_regs

  task t_sources;
    for (int b = 0; b < 7; b++) begin
      m = 8'h01 << b;
      o = (b == 6) ? 8'h01 : (m << 1);
      bus(1'b1, INTERRUPT_ENABLE_ADDR, 8'h80 | m, 4'h1);
      det(o);
      chk({7'h00, irq}, 8'h00);
      det(o | m);
      bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
      chk(d, o | m);
      chk({1'b0, status_change}, 8'h00);
      det(o);
      chk({7'h00, irq}, 8'h01);
      chk({1'b0, status_change}, m);
      bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
      chk({7'h00, irq}, 8'h00);
      bus(1'b1, INTERRUPT_ENABLE_ADDR, m, 4'h1);
      det(o | m);
      chk({7'h00, irq}, 8'h00);
      det(8'h00);
      bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
    end
  endtask : t_sources

  task t_loop(input loop_mode_type md);
    @(posedge ref_clk);
    loop_mode <= md;
    alarm_in.loop_pattern_present <= 1'b1;
    bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
    chk(d, 8'h00);
    repeat (10) @(posedge ref_clk);
    bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
    chk(d, 8'h08);
    alarm_in.loop_pattern_present <= 1'b0;
    repeat (2) @(posedge ref_clk);
    bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
    chk(d, 8'h00);
  endtask : t_loop

  // Reset, then each scenario in turn
  initial begin
    reset     = 1'b1;
    alarm_in  = '0;
    loop_mode = LOOP_AUTO;
    fails     = 0;
    samples_checked = 0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    t_sources;
    t_loop(LOOP_MANUAL_A);
    t_loop(LOOP_MANUAL_B);
    loop_mode <= LOOP_OFF;
    det(8'h08);
    bus(1'b0, ALARM_STATUS_ADDR, 8'h00, 4'hF);
    chk(d, 8'h00);
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
